// File: common/fid_pkg.sv
// Shared constants and types for the flash instruction host controller
package fid_pkg;

  // Register offsets (byte addresses, one aligned word each)
  localparam logic [5:0] REG_CTRL   = 6'h00;
  localparam logic [5:0] REG_ADDR   = 6'h04;
  localparam logic [5:0] REG_WDATA  = 6'h08;
  localparam logic [5:0] REG_SEL    = 6'h0C;
  localparam logic [5:0] REG_STATUS = 6'h10;
  localparam logic [5:0] REG_RDATA  = 6'h14;
  localparam logic [5:0] REG_BAD    = 6'h18;

  // Field positions
  localparam int CTRL_START   = 0;
  localparam int CTRL_OP_LSB  = 1;
  localparam int ST_BUSY      = 0;
  localparam int ST_DONE      = 1;
  localparam int ST_ERROR     = 2;
  localparam int ST_REFUSED   = 3;
  localparam int SEL_PRIM_LSB = 0;
  localparam int SEL_SEC_LSB  = 8;

  // Status bits in a flash data read
  localparam int BIT_POLL   = 7;
  localparam int BIT_FLIP   = 6;
  localparam int BIT_FAIL   = 5;
  localparam int BIT_WINDOW = 3;

  // Instruction bytes and addresses (low twelve bits only)
  localparam logic [7:0]  CODE_UNLOCK1 = 8'hAA;
  localparam logic [7:0]  CODE_UNLOCK2 = 8'h55;
  localparam logic [7:0]  CMD_ID       = 8'h90;
  localparam logic [7:0]  CMD_PROGRAM  = 8'hA0;
  localparam logic [7:0]  CMD_ERASE    = 8'h80;
  localparam logic [7:0]  CMD_SECTOR   = 8'h30;
  localparam logic [7:0]  CMD_BULK     = 8'h10;
  localparam logic [7:0]  CMD_RESET    = 8'hF0;
  localparam logic [11:0] ADDR_UNLOCK1 = 12'h555;
  localparam logic [11:0] ADDR_UNLOCK2 = 12'hAAA;
  localparam logic [11:0] ADDR_ID      = 12'h001;
  localparam logic [11:0] ADDR_PROT    = 12'h002;

  // Timing
  localparam int CLK_NS      = 40;
  localparam int T_STROBE_NS = 120;
  localparam int STROBE_CYC  = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    OP_READ, OP_PROGRAM, OP_SECTOR_ERASE, OP_BULK_ERASE,
    OP_READ_ID, OP_READ_PROT, OP_RESET
  } fid_op_t;

  typedef enum logic [1:0] {K_WR, K_RD, K_POLL, K_END} fid_kind_t;

  typedef struct packed {
    fid_kind_t   kind;
    logic        user_addr;
    logic        user_data;
    logic [11:0] addr;
    logic [7:0]  data;
  } fid_step_t;

  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_FETCH  = 3'b001,
    S_SETUP  = 3'b011,
    S_STROBE = 3'b111,
    S_HOLD   = 3'b101
  } fid_state_t;

endpackage

// File: hw/fid_host.sv
// Host controller sequencing flash instructions, driven over AXI4-Lite
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// (R1) Flash decodes written bytes as instruction steps; host sends them back to back.
// (R2) Bad byte or long gap aborts to read mode; host never pauses mid-instruction.
// (R3) Every coded instruction starts with AA at 555 then 55 at AAA.
// (R4) Upper address bits ignored; host keeps a sector select high each cycle.
// (R5) Bank follows which select group is high; identifier only on primary bank.
// (R6) Flash resets to read mode at power-up and locks writes at low supply.
// (R7) Host holds selects low and write strobe high through reset.
// (R8) Outside instructions flash reads behave like a ROM.
// (R9) Identifier read: three writes, then read with A6,A1,A0 = 0,0,1, primary select.
// (R10) Protection read: three writes, then read with A6,A1,A0 = 0,1,0.
// (R11) During program or erase, reads return status bits 7, 6, 5, 3.
// (R12) Poll bit reads inverted data bit 7 while programming, true afterwards.
// (R13) Status polling starts only after write four (program) or six (erase).
// (R14) Poll bit reads 0 during erase, 1 once erased.
// (R15) Program into a protected sector is silently ignored.
// (R16) Erase of only protected sectors: poll bit 0 about 100 us, no erase.
// (R17) Toggle bit inverts on each read while an operation runs.
// (R18) Host treats two identical successive reads as completion.
// (R19) Erase of only protected sectors: toggle bit 0 about 100 us.
// (R20) Error bit set on program or erase failure, else 0.
// (R21) Error bit cleared only by the reset instruction.
// (R22) Host stops using a sector after its program or erase failed.
// (R23) Erase window bit 0 for about 120 us after sector erase.
// (R24) Only the twelve low address bits take part in instruction decoding.
// (R25) After identifier, protection read or error, host sends the reset instruction.
// (R26) Flash times gaps between bytes with an internal timer.
module fid_host
  import fid_pkg::*;
#(
  parameter int FLASH_AW = 16
) (
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite write
  input  wire logic [5:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read
  input  wire logic [5:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Flash bus
  output logic [FLASH_AW-1:0]        flash_addr,
  output logic [7:0]                 flash_dq_out,
  output logic                       flash_dq_oe,
  input  wire logic [7:0]            flash_dq_in,
  output logic                       flash_we_n,
  output logic                       flash_oe_n,
  output logic [7:0]                 primary_sector_selects,
  output logic [3:0]                 secondary_sector_selects
);

  generate
    if (FLASH_AW < 13 || FLASH_AW > 32) begin : g_bad_aw
      $error("FLASH_AW must be 13 to 32");
    end
  endgenerate

  fid_state_t            state;
  fid_op_t               run_op;
  fid_step_t             cur_reg;
  fid_step_t             nxt;
  logic [3:0]            idx_reg;
  logic [1:0]            cnt_reg;
  logic [2:0]            wr_cnt;
  logic [7:0]            rd_cur;
  logic [7:0]            rd_prev;
  logic                  prev_valid;
  logic                  fail_seen;
  logic [FLASH_AW-1:0]   addr_reg;
  logic [7:0]            wdata_reg;
  logic [11:0]           sel_reg;
  logic [11:0]           bad_reg;
  logic                  done_reg;
  logic                  error_reg;
  logic                  refused_reg;
  logic [31:0]           rd_mux;
  logic                  rd_hit;

  function automatic fid_step_t mk(input fid_kind_t k, input logic ua, input logic ud,
                                   input logic [11:0] a, input logic [7:0] d);
    mk = '{kind: k, user_addr: ua, user_data: ud, addr: a, data: d};
  endfunction

  // Cycle table of each instruction
  function automatic fid_step_t step_of(input fid_op_t op, input logic [3:0] idx);
    fid_step_t s;
    s = mk(K_END, 1'b0, 1'b0, 12'h000, 8'h00);
    if (op == OP_READ) begin
      if (idx == 4'h0) s = mk(K_RD, 1'b1, 1'b0, 12'h000, 8'h00);
    end else if (op == OP_RESET) begin
      if (idx == 4'h0) s = mk(K_WR, 1'b1, 1'b0, 12'h000, CMD_RESET);
    end else if (idx == 4'h0) begin
      s = mk(K_WR, 1'b0, 1'b0, ADDR_UNLOCK1, CODE_UNLOCK1); // see R3
    end else if (idx == 4'h1) begin
      s = mk(K_WR, 1'b0, 1'b0, ADDR_UNLOCK2, CODE_UNLOCK2); // see R3
    end else begin
      case (op)
        OP_PROGRAM: begin
          if (idx == 4'h2) s = mk(K_WR, 1'b0, 1'b0, ADDR_UNLOCK1, CMD_PROGRAM);
          if (idx == 4'h3) s = mk(K_WR, 1'b1, 1'b1, 12'h000, 8'h00);
          if (idx == 4'h4) s = mk(K_POLL, 1'b1, 1'b0, 12'h000, 8'h00); // see R13
        end
        OP_SECTOR_ERASE, OP_BULK_ERASE: begin
          if (idx == 4'h2) s = mk(K_WR, 1'b0, 1'b0, ADDR_UNLOCK1, CMD_ERASE);
          if (idx == 4'h3) s = mk(K_WR, 1'b0, 1'b0, ADDR_UNLOCK1, CODE_UNLOCK1);
          if (idx == 4'h4) s = mk(K_WR, 1'b0, 1'b0, ADDR_UNLOCK2, CODE_UNLOCK2);
          if (idx == 4'h5 && op == OP_SECTOR_ERASE)
            s = mk(K_WR, 1'b1, 1'b0, 12'h000, CMD_SECTOR);
          if (idx == 4'h5 && op == OP_BULK_ERASE)
            s = mk(K_WR, 1'b0, 1'b0, ADDR_UNLOCK1, CMD_BULK);
          if (idx == 4'h6) s = mk(K_POLL, 1'b1, 1'b0, 12'h000, 8'h00); // see R13
        end
        OP_READ_ID, OP_READ_PROT: begin
          if (idx == 4'h2) s = mk(K_WR, 1'b0, 1'b0, ADDR_UNLOCK1, CMD_ID);
          if (idx == 4'h3)
            s = mk(K_RD, 1'b0, 1'b0, (op == OP_READ_ID) ? ADDR_ID : ADDR_PROT, 8'h00);
          if (idx == 4'h4) s = mk(K_WR, 1'b1, 1'b0, 12'h000, CMD_RESET); // see R25
        end
        default: s = mk(K_END, 1'b0, 1'b0, 12'h000, 8'h00);
      endcase
    end
    return s;
  endfunction

  // Command acceptance
  logic    wr_hs;
  logic    rd_hs;
  logic    ctrl_start;
  logic    start_ok;
  logic    start_go;
  fid_op_t op_req;
  logic    erase_or_prog;
  logic    poll_ok;
  logic    poll_bad;
  logic    done_evt;
  logic    err_evt;

  assign wr_hs      = s_axi_awready && s_axi_awvalid && s_axi_wready && s_axi_wvalid;
  assign rd_hs      = s_axi_arready && s_axi_arvalid;
  assign ctrl_start = wr_hs && s_axi_awaddr == REG_CTRL && s_axi_wstrb[0]
                      && s_axi_wdata[CTRL_START];
  assign op_req     = fid_op_t'(s_axi_wdata[CTRL_OP_LSB +: 3]);
  assign erase_or_prog = op_req == OP_PROGRAM || op_req == OP_SECTOR_ERASE
                         || op_req == OP_BULK_ERASE;
  // A select is needed for any access; identifier lives on primary bank only
  assign start_ok   = state == S_IDLE && op_req <= OP_RESET && sel_reg != 12'h000 // see R4
                      && !(op_req == OP_READ_ID && sel_reg[7:0] == 8'h00)           // see R5
                      && !(erase_or_prog && (sel_reg & bad_reg) != 12'h000);        // see R22
  assign start_go   = ctrl_start && start_ok;
  assign nxt        = step_of(run_op, idx_reg);
  assign poll_ok    = prev_valid && rd_cur == rd_prev; // see R18
  assign poll_bad   = !poll_ok && fail_seen;
  assign done_evt   = state == S_FETCH && nxt.kind == K_END;
  assign err_evt    = state == S_HOLD && cur_reg.kind == K_POLL && poll_bad;

  // Sequencer and flash pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state                    <= S_IDLE;
      run_op                   <= OP_READ;
      cur_reg                  <= '0;
      idx_reg                  <= 4'h0;
      cnt_reg                  <= 2'h0;
      wr_cnt                   <= 3'h0;
      rd_cur                   <= 8'h00;
      rd_prev                  <= 8'h00;
      prev_valid               <= 1'b0;
      fail_seen                <= 1'b0;
      flash_addr               <= '0;
      flash_dq_out             <= 8'h00;
      flash_dq_oe              <= 1'b0;
      flash_we_n               <= 1'b1; // see R7
      flash_oe_n               <= 1'b1;
      primary_sector_selects   <= 8'h00; // see R7
      secondary_sector_selects <= 4'h0;
    end else begin
      case (state)
        S_IDLE: begin
          if (start_go) begin
            run_op     <= op_req;
            idx_reg    <= 4'h0;
            wr_cnt     <= 3'h0;
            prev_valid <= 1'b0;
            fail_seen  <= 1'b0;
            state      <= S_FETCH;
          end
        end
        S_FETCH: begin
          cur_reg <= nxt;
          if (nxt.kind == K_END) begin
            state <= S_IDLE;
          end else begin
            // Upper bits carry the user address; decode uses the low twelve
            flash_addr <= nxt.user_addr ? addr_reg
                                        : {addr_reg[FLASH_AW-1:12], nxt.addr}; // see R24
            flash_dq_out             <= nxt.user_data ? wdata_reg : nxt.data;
            flash_dq_oe              <= nxt.kind == K_WR;
            primary_sector_selects   <= sel_reg[SEL_PRIM_LSB +: 8]; // see R4
            secondary_sector_selects <= sel_reg[SEL_SEC_LSB +: 4];
            state                    <= S_SETUP;
          end
        end
        S_SETUP: begin
          if (cur_reg.kind == K_WR) begin
            flash_we_n <= 1'b0;
          end else begin
            flash_oe_n <= 1'b0;
          end
          cnt_reg <= 2'(STROBE_CYC - 1);
          state   <= S_STROBE;
        end
        S_STROBE: begin
          if (cnt_reg == 2'h0) begin
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            if (cur_reg.kind == K_WR) begin
              wr_cnt <= wr_cnt + 3'h1;
            end else begin
              rd_cur <= flash_dq_in;
            end
            state <= S_HOLD;
          end else begin
            cnt_reg <= cnt_reg - 2'h1;
          end
        end
        S_HOLD: begin
          // Short gap keeps the next byte well inside the flash timeout
          flash_dq_oe              <= 1'b0; // see R1
          primary_sector_selects   <= 8'h00;
          secondary_sector_selects <= 4'h0;
          state                    <= S_FETCH;
          if (cur_reg.kind != K_POLL) begin
            idx_reg <= idx_reg + 4'h1;
          end else if (poll_ok) begin
            idx_reg <= idx_reg + 4'h1; // see R18
          end else if (poll_bad) begin
            // Still toggling after fail bit seen: abort with reset
            run_op  <= OP_RESET; // see R25
            idx_reg <= 4'h0;
          end else begin
            // Fail bit may rise with the last toggle, so read once more
            fail_seen  <= rd_cur[BIT_FAIL]; // see R20
            rd_prev    <= rd_cur;
            prev_valid <= 1'b1;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Sticky status, write one to clear; a set in the same cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_reg    <= 1'b0;
      error_reg   <= 1'b0;
      refused_reg <= 1'b0;
      bad_reg     <= 12'h000;
    end else begin
      if (done_evt) begin
        done_reg <= 1'b1;
      end else if (wr_hs && s_axi_awaddr == REG_STATUS && s_axi_wstrb[0]
                   && s_axi_wdata[ST_DONE]) begin
        done_reg <= 1'b0;
      end
      if (err_evt) begin
        error_reg <= 1'b1;
      end else if (wr_hs && s_axi_awaddr == REG_STATUS && s_axi_wstrb[0]
                   && s_axi_wdata[ST_ERROR]) begin
        error_reg <= 1'b0;
      end
      if (ctrl_start && !start_ok) begin
        refused_reg <= 1'b1;
      end else if (wr_hs && s_axi_awaddr == REG_STATUS && s_axi_wstrb[0]
                   && s_axi_wdata[ST_REFUSED]) begin
        refused_reg <= 1'b0;
      end
      if (err_evt) begin
        bad_reg <= bad_reg | sel_reg; // see R22
      end else if (wr_hs && s_axi_awaddr == REG_BAD) begin
        bad_reg <= bad_reg & ~s_axi_wdata[11:0];
      end
    end
  end

  // Read decode
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    if (s_axi_araddr == REG_CTRL) begin
      rd_mux = {28'h0, run_op, 1'b0};
    end else if (s_axi_araddr == REG_ADDR) begin
      rd_mux = 32'(addr_reg);
    end else if (s_axi_araddr == REG_WDATA) begin
      rd_mux = {24'h0, wdata_reg};
    end else if (s_axi_araddr == REG_SEL) begin
      rd_mux = {20'h0, sel_reg};
    end else if (s_axi_araddr == REG_STATUS) begin
      rd_mux = {28'h0, refused_reg, error_reg, done_reg, state != S_IDLE};
    end else if (s_axi_araddr == REG_RDATA) begin
      rd_mux = {24'h0, rd_cur};
    end else if (s_axi_araddr == REG_BAD) begin
      rd_mux = {20'h0, bad_reg};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // AXI4-Lite slave; configuration frozen while an instruction runs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
      addr_reg      <= '0;
      wdata_reg     <= 8'h00;
      sel_reg       <= 12'h000;
    end else begin
      s_axi_awready <= !s_axi_awready && !s_axi_bvalid && s_axi_awvalid && s_axi_wvalid;
      s_axi_wready  <= !s_axi_awready && !s_axi_bvalid && s_axi_awvalid && s_axi_wvalid;
      if (wr_hs) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (s_axi_awaddr <= REG_BAD && s_axi_awaddr[1:0] == 2'b00)
                        ? RESP_OKAY : RESP_SLVERR;
        if (state == S_IDLE) begin
          if (s_axi_awaddr == REG_ADDR) begin
            for (int i = 0; i < FLASH_AW; i++) begin
              if (s_axi_wstrb[i / 8]) begin
                addr_reg[i] <= s_axi_wdata[i];
              end
            end
          end else if (s_axi_awaddr == REG_WDATA && s_axi_wstrb[0]) begin
            wdata_reg <= s_axi_wdata[7:0];
          end else if (s_axi_awaddr == REG_SEL) begin
            if (s_axi_wstrb[0]) sel_reg[7:0] <= s_axi_wdata[7:0];
            if (s_axi_wstrb[1]) sel_reg[11:8] <= s_axi_wdata[11:8];
          end
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rd_hs) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_we_pulse;
    (!flash_we_n && (primary_sector_selects != 8'h00 || secondary_sector_selects != 4'h0))[*3]
      ##1 flash_we_n;
  endsequence
  sequence s_finish;
    state == S_FETCH ##1 done_reg;
  endsequence
  sequence s_reset_write;
    ##[1:8] ($fell(flash_we_n) && flash_dq_out == CMD_RESET);
  endsequence

  property p_unlock;
    ($fell(flash_we_n) && run_op != OP_RESET && run_op != OP_READ) |->
      (wr_cnt == 3'h0 && flash_dq_out == CODE_UNLOCK1 && flash_addr[11:0] == ADDR_UNLOCK1)
      || (wr_cnt == 3'h1 && flash_dq_out == CODE_UNLOCK2 && flash_addr[11:0] == ADDR_UNLOCK2)
      || wr_cnt >= 3'h2;
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock pair wrong"); // see R3
  property p_sel_strobe;
    $fell(flash_we_n) |-> s_we_pulse;
  endproperty
  a_sel_strobe: assert property (p_sel_strobe) else $error("write without select"); // see R4
  property p_powerup;
    $rose(aresetn) |-> flash_we_n && flash_oe_n && primary_sector_selects == 8'h00
                       && secondary_sector_selects == 4'h0;
  endproperty
  a_powerup: assert property (p_powerup) else $error("pins active at reset"); // see R7
  property p_id_addr;
    ($fell(flash_oe_n) && run_op == OP_READ_ID) |->
      flash_addr[6] == 1'b0 && flash_addr[1:0] == 2'b01 && primary_sector_selects != 8'h00;
  endproperty
  a_id_addr: assert property (p_id_addr) else $error("identifier read address"); // see R9
  property p_prot_addr;
    ($fell(flash_oe_n) && run_op == OP_READ_PROT) |->
      flash_addr[6] == 1'b0 && flash_addr[1:0] == 2'b10;
  endproperty
  a_prot_addr: assert property (p_prot_addr) else $error("protection read address"); // see R10
  property p_poll_late;
    ($fell(flash_oe_n) && cur_reg.kind == K_POLL) |->
      (run_op == OP_PROGRAM && wr_cnt == 3'h4) || (run_op != OP_PROGRAM && wr_cnt == 3'h6);
  endproperty
  a_poll_late: assert property (p_poll_late) else $error("poll too early"); // see R13
  property p_toggle_done;
    (state == S_HOLD && cur_reg.kind == K_POLL && poll_ok) |=> s_finish;
  endproperty
  a_toggle_done: assert property (p_toggle_done) else $error("stable reads not done"); // see R18
  property p_bad_sector;
    start_go |-> !erase_or_prog || (sel_reg & bad_reg) == 12'h000;
  endproperty
  a_bad_sector: assert property (p_bad_sector) else $error("failed sector reused"); // see R22
  property p_reset_after;
    ((state == S_HOLD && cur_reg.kind == K_RD && run_op inside {OP_READ_ID, OP_READ_PROT})
      || err_evt) |-> s_reset_write;
  endproperty
  a_reset_after: assert property (p_reset_after) else $error("no reset instruction"); // see R25

endmodule

`default_nettype wire

// File: verif/fid_flash_model.sv
// Behavioural flash device seen by the host controller
`timescale 1ns/100ps
`default_nettype none
module fid_flash_model
  import fid_pkg::*;
#(
  parameter logic [7:0] ID_CODE = 8'h3C, // Arbitrary value
  parameter logic [7:0] PROT    = 8'h80
) (
  // Host side pins
  input  wire logic        aclk,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  dq,
  input  wire logic        den,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic [7:0]  psel,
  input  wire logic [3:0]  ssel,
  output logic [7:0]       dq_in
);
  logic [7:0] mem [16];
  logic [2:0] cyc = 3'h0;
  logic       idm = 1'b0;
  logic       ers = 1'b0;
  logic       fail = 1'b0;
  logic       tog = 1'b0;
  logic       we_q = 1'b1;
  logic       oe_q = 1'b1;
  logic [7:0] pd = 8'hFF;
  logic [7:0] last = 8'h00;
  logic [7:0] val;
  int         busy = 0, gap = 0;
  wire        cmd = (addr[11:0] == ADDR_UNLOCK1);
  wire        ul2 = (addr[11:0] == ADDR_UNLOCK2);
  wire        win = busy < 31;
  wire        blk = ers && |(psel & PROT);
  initial foreach (mem[i]) mem[i] = 8'hFF;
  always_comb begin
    if (busy != 0) val = {~(ers | pd[7]), tog & !blk, fail, 1'b0, win, 3'h0};
    else if (idm && {addr[6], addr[1:0]} == 3'b001 && |psel) val = ID_CODE;
    else if (idm && {addr[6], addr[1:0]} == 3'b010) val = {7'h00, |(psel & PROT)};
    else val = mem[addr[3:0]];
  end
  // Released bus shows a changing value, never the last byte
  assign dq_in = oe_n ? ~last : val;
  always @(posedge aclk) begin
    we_q <= we_n;
    oe_q <= oe_n;
    gap <= (we_n && !we_q) ? 0 : gap + 1;
    if (!oe_n) last <= val;
    if (oe_n && !oe_q && busy != 0) tog <= ~tog;
    if (busy != 0 && !fail) busy <= busy - 1;
    if (we_n && !we_q && den && (|psel || |ssel)) begin
      cyc <= 3'h0;
      idm <= 1'b0;
      if (dq == CMD_RESET) begin
        fail <= 1'b0;
        busy <= 0;
      end else if (busy == 0) case (gap > 40 ? 3'h0 : cyc)
        3'h0: if (dq == CODE_UNLOCK1 && cmd) cyc <= 3'h1;
        3'h1: if (dq == CODE_UNLOCK2 && ul2) cyc <= 3'h2;
        3'h2: if (cmd) begin
          if (dq == CMD_ID) idm <= 1'b1;
          if (dq == CMD_PROGRAM) cyc <= 3'h3;
          if (dq == CMD_ERASE) cyc <= 3'h4;
        end
        3'h3: if (!(|(psel & PROT))) begin
          fail <= |(dq & ~mem[addr[3:0]]);
          mem[addr[3:0]] <= mem[addr[3:0]] & dq;
          pd <= dq;
          ers <= 1'b0;
          busy <= 30;
        end
        3'h4: if (dq == CODE_UNLOCK1 && cmd) cyc <= 3'h5;
        3'h5: if (dq == CODE_UNLOCK2 && ul2) cyc <= 3'h6;
        3'h6: if (dq == CMD_SECTOR || (dq == CMD_BULK && cmd)) begin
          if (!(|(psel & PROT))) foreach (mem[i]) mem[i] <= 8'hFF;
          ers <= 1'b1;
          busy <= 40;
        end
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: verif/test_fid_host.sv
// Self-checking bench for the flash instruction host controller
`timescale 1ns/100ps
`default_nettype none
module test_fid_host
  import fid_pkg::*;
;
  typedef struct packed {
    logic [2:0]  op;
    logic [11:0] sel;
    logic [7:0]  a;
    logic [7:0]  d;
    logic [3:0]  st;
    logic [8:0]  rdx;
    logic [11:0] bad;
  } fid_tstep_t;
  localparam logic [7:0] ID_C = 8'h3C; // Arbitrary value
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0, rd_d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] rd_r;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic flash_we_n, flash_oe_n, flash_dq_oe;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [15:0] flash_addr;
  wire logic [7:0] flash_dq_out, flash_dq_in, primary_sector_selects;
  wire logic [3:0] secondary_sector_selects;
  int n_fail = 0, total_checks = 0, cyc = 0;
  fid_tstep_t tbl [19] = '{
    '{OP_READ_ID,      12'h001, 8'h00, 8'h00, 4'h2, {1'b0, ID_C}, 12'h0},
    '{OP_READ_PROT,    12'h080, 8'h00, 8'h00, 4'h2, 9'h001, 12'h0},
    '{OP_READ_PROT,    12'h001, 8'h00, 8'h00, 4'h2, 9'h000, 12'h0},
    '{OP_READ,         12'h001, 8'h03, 8'h00, 4'h2, 9'h0FF, 12'h0},
    '{OP_PROGRAM,      12'h001, 8'h03, 8'h5A, 4'h2, 9'h05A, 12'h0},
    '{OP_READ,         12'h001, 8'h03, 8'h00, 4'h2, 9'h05A, 12'h0},
    '{OP_PROGRAM,      12'h001, 8'h03, 8'hFF, 4'h6, 9'h100, 12'h1},
    '{OP_PROGRAM,      12'h001, 8'h05, 8'h00, 4'h8, 9'h100, 12'h1},
    '{OP_READ,         12'h001, 8'h03, 8'h00, 4'h2, 9'h05A, 12'h0},
    '{OP_PROGRAM,      12'h080, 8'h04, 8'h00, 4'h2, 9'h0FF, 12'h0},
    '{OP_READ,         12'h080, 8'h04, 8'h00, 4'h2, 9'h0FF, 12'h0},
    '{OP_SECTOR_ERASE, 12'h080, 8'h04, 8'h00, 4'h2, 9'h100, 12'h0},
    '{OP_SECTOR_ERASE, 12'h001, 8'h03, 8'h00, 4'h2, 9'h0FF, 12'h0},
    '{OP_READ,         12'h001, 8'h03, 8'h00, 4'h2, 9'h0FF, 12'h0},
    '{OP_BULK_ERASE,   12'h100, 8'h00, 8'h00, 4'h2, 9'h0FF, 12'h0},
    '{OP_READ_ID,      12'h100, 8'h00, 8'h00, 4'h8, 9'h100, 12'h0},
    '{OP_READ,         12'h000, 8'h00, 8'h00, 4'h8, 9'h100, 12'h0},
    '{3'h7,            12'h001, 8'h00, 8'h00, 4'h8, 9'h100, 12'h0},
    '{OP_RESET,        12'h001, 8'h03, 8'h00, 4'h2, 9'h100, 12'h0}};
  always #20 aclk = ~aclk;
  fid_host fid_host_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .flash_addr, .flash_dq_out, .flash_dq_oe, .flash_dq_in,
    .flash_we_n, .flash_oe_n, .primary_sector_selects, .secondary_sector_selects);
  fid_flash_model #(.ID_CODE(ID_C), .PROT(8'h80)) fid_flash_model_inst (.aclk(aclk),
    .addr(flash_addr), .dq(flash_dq_out), .we_n(flash_we_n), .oe_n(flash_oe_n), .den(flash_dq_oe),
    .psel(primary_sector_selects), .ssel(secondary_sector_selects), .dq_in(flash_dq_in));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
  endtask
  task automatic rd(input logic [5:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd_d = s_axi_rdata;
    rd_r = s_axi_rresp;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    repeat (2) @(posedge aclk);
    chk("we_n in reset", 32'h1, {31'h0, flash_we_n});
    chk("selects in reset", 32'h0, {20'h0, primary_sector_selects, secondary_sector_selects});
    aresetn <= 1'b1;
    rd(6'h1C);
    wr(6'h1C, 32'h0);
    chk("unmapped resp", {28'h0, RESP_SLVERR, RESP_SLVERR}, {28'h0, rd_r, s_axi_bresp});
    foreach (tbl[i]) begin
      wr(REG_SEL, {20'h0, tbl[i].sel});
      wr(REG_ADDR, {24'h0, tbl[i].a});
      wr(REG_WDATA, {24'h0, tbl[i].d});
      wr(REG_CTRL, {28'h0, tbl[i].op, 1'b1});
      rd(REG_STATUS);
      while (rd_d[ST_DONE] !== 1'b1 && rd_d[ST_REFUSED] !== 1'b1) rd(REG_STATUS);
      chk("status", {28'h0, tbl[i].st}, rd_d);
      rd(REG_RDATA);
      if (!tbl[i].rdx[8]) chk("rdata", {24'h0, tbl[i].rdx[7:0]}, rd_d);
      rd(REG_BAD);
      chk("bad sectors", {20'h0, tbl[i].bad}, rd_d);
      wr(REG_STATUS, 32'hE);
      if (tbl[i].st[ST_REFUSED]) wr(REG_BAD, 32'hFFF);
    end
    summarize();
  end
endmodule
`default_nettype wire
